// ### hdl/fsp_consts.vh
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH
// register offsets on the plain register port
`define FSP_ADDR_OPT 2'h0
`define FSP_ADDR_CFG 2'h1
`define FSP_ADDR_PROT 2'h2
`define FSP_ADDR_STAT 2'h3
// options field positions
`define FSP_OPT_BACKDOOR_ENABLE 7
`define FSP_OPT_NORED 6
`define FSP_OPT_MASK 8'hC3
// configuration field positions
`define FSP_CFG_KEYSEL 5
`define FSP_CFG_MASK 8'hE0
// protection field positions
`define FSP_PROT_OPEN 7
`define FSP_PROT_OFF 6
`define FSP_PROT_MASK 8'hF8
// security codes
`define FSP_SEC_UNSECURED 2'h2
// key window and vector table
`define FSP_KEY_BASE 16'hFFB0
`define FSP_KEY_TOP 16'hFFB7
`define FSP_VEC_BASE 16'hFFC0
`define FSP_VEC_RESET 16'hFFFE
`define FSP_VEC_TOP 16'hFFFF
`define FSP_SIZE_LAST 3'h7
`define FSP_LAST_LOW 16'h182C
// reset values
`define FSP_CFG_RESET 8'h00
`endif

// ### hdl/fsp_flash_protect.v
`timescale 1ns/1ps
`include "fsp_consts.vh"
module fsp_flash_protect #(
	parameter MEM_KB = 60
)(
	// clock and reset
	input wire ref_clk_i,
	input wire rst_n_i,
	// nonvolatile bytes and stored key, stable during reset
	input wire [7:0] options_nv_byte_i,
	input wire [7:0] protection_nv_byte_i,
	input wire [63:0] stored_backdoor_key_i,
	// register port
	input wire [1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire background_debug_mode_i,
	output reg [7:0] reg_rdata_o,
	// flash bus write (key window steering)
	input wire flash_wr_i,
	input wire [15:0] flash_waddr_i,
	input wire [7:0] flash_wdata_i,
	input wire flash_wr_debug_i,
	output wire cmd_launch_o,
	// blank check result from sequencer
	input wire blank_ok_i,
	// memory access checks
	input wire [15:0] pe_addr_i,
	output wire pe_allowed_o,
	input wire access_unsecured_src_i,
	output wire access_block_o,
	output wire flash_read_invalid_o,
	// vector fetch
	input wire [15:0] vec_addr_i,
	output wire [15:0] vec_addr_o,
	// status
	output wire secure_o,
	output wire redirect_active_o
);
	// shadow registers loaded once after reset, plus the configuration register and the load flag
	reg [7:0] opt_q;
	reg [7:0] cfg_q;
	reg [7:0] prot_q;
	reg loaded_q;

	// comparison key collected from firmware writes
	reg [63:0] key_q;
	reg [7:0] key_seen_q;

	// decoded write strobes and key window state
	reg key_sel;
	reg in_key_win;
	reg [2:0] key_idx;
	reg key_write;
	reg cfg_write;
	reg prot_write;
	reg key_clear;
	reg key_match;
	reg unlock;

	// protection decode
	reg [2:0] size_code;
	reg [15:0] prot_base;
	reg in_block;
	reg pe_ok;

	// vector redirection decode
	reg variant_ok;
	reg redirect_on;
	reg is_vec;
	reg [15:0] redir_base;
	reg [15:0] redir;
	reg [15:0] vec_out;

	// read data selected for the next cycle
	reg [7:0] rdata_d;

	// inclusive address range test
	function fsp_in_range;
		input [15:0] addr;
		input [15:0] lo;
		input [15:0] hi;
		begin
			fsp_in_range = (addr >= lo) && (addr <= hi);
		end
	endfunction

	// lowest protected address for a size code
	function [15:0] fsp_prot_base;
		input [2:0] code;
		begin
			case (code)
				3'h0: fsp_prot_base = 16'hFE00;
				3'h1: fsp_prot_base = 16'hFC00;
				3'h2: fsp_prot_base = 16'hF800;
				3'h3: fsp_prot_base = 16'hF000;
				3'h4: fsp_prot_base = 16'hE000;
				3'h5: fsp_prot_base = 16'hC000;
				3'h6: fsp_prot_base = 16'h8000;
				default: fsp_prot_base = `FSP_LAST_LOW;
			endcase
		end
	endfunction

	// base of the table just below the protected block
	function [15:0] fsp_redir_base;
		input [2:0] code;
		begin
			case (code)
				3'h0: fsp_redir_base = 16'hFDC0;
				3'h1: fsp_redir_base = 16'hFBC0;
				3'h2: fsp_redir_base = 16'hF7C0;
				3'h3: fsp_redir_base = 16'hEFC0;
				3'h4: fsp_redir_base = 16'hDFC0;
				3'h5: fsp_redir_base = 16'hBFC0;
				3'h6: fsp_redir_base = 16'h7FC0;
				default: fsp_redir_base = 16'h0000;
			endcase
		end
	endfunction

	// security field decode, only one code opens the part
	function fsp_is_open;
		input [1:0] code;
		begin
			fsp_is_open = (code == `FSP_SEC_UNSECURED);
		end
	endfunction

	// register and key window strobes
	always @*
	begin
		key_sel = cfg_q[`FSP_CFG_KEYSEL];
		in_key_win = fsp_in_range(flash_waddr_i, `FSP_KEY_BASE, `FSP_KEY_TOP);
		key_idx = flash_waddr_i[2:0];
		key_write = 1'b0;
		if (flash_wr_i && in_key_win && key_sel)
		begin
			key_write = !flash_wr_debug_i;
		end
		cfg_write = reg_wr_i && (reg_addr_i == `FSP_ADDR_CFG);
		prot_write = 1'b0;
		if (reg_wr_i && (reg_addr_i == `FSP_ADDR_PROT))
		begin
			prot_write = background_debug_mode_i;
		end
		key_clear = cfg_write && key_sel && !reg_wdata_i[`FSP_CFG_KEYSEL];
	end

	// key comparison and unlock decision
	always @*
	begin
		key_match = (key_seen_q == 8'hFF) && (key_q == stored_backdoor_key_i);
		unlock = 1'b0;
		if (key_clear && key_match)
		begin
			unlock = opt_q[`FSP_OPT_BACKDOOR_ENABLE];
		end
		if (blank_ok_i)
		begin
			unlock = 1'b1;
		end
	end

	// load flag, high from the first edge after reset
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			loaded_q <= 1'b0;
		end
		else
		begin
			loaded_q <= 1'b1;
		end
	end

	// options shadow: loaded once, software writes ignored
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			opt_q <= 8'h00;
		end
		else if (!loaded_q)
		begin
			opt_q <= options_nv_byte_i & `FSP_OPT_MASK;
		end
		else if (unlock)
		begin
			opt_q[1:0] <= `FSP_SEC_UNSECURED;
		end
	end

	// protection shadow: loaded once, then debug writes only
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prot_q <= 8'h00;
		end
		else if (!loaded_q)
		begin
			prot_q <= protection_nv_byte_i & `FSP_PROT_MASK;
		end
		else if (prot_write)
		begin
			prot_q <= reg_wdata_i & `FSP_PROT_MASK;
		end
	end

	// configuration register, low bits held at zero
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cfg_q <= `FSP_CFG_RESET;
		end
		else if (cfg_write)
		begin
			cfg_q <= reg_wdata_i & `FSP_CFG_MASK;
		end
	end

	// key bytes, byte n of the window lands in key byte n
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			key_q <= 64'h0000000000000000;
		end
		else if (key_write)
		begin
			key_q[(7 - key_idx) * 8 +: 8] <= flash_wdata_i;
		end
	end

	// which key bytes were written since the last compare
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			key_seen_q <= 8'h00;
		end
		else if (key_clear)
		begin
			key_seen_q <= 8'h00;
		end
		else if (key_write)
		begin
			key_seen_q[key_idx] <= 1'b1;
		end
	end

	// read mux, unused addresses read zero
	always @*
	begin
		rdata_d = 8'h00;
		case (reg_addr_i)
			`FSP_ADDR_OPT:
			begin
				rdata_d = opt_q;
			end
			`FSP_ADDR_CFG:
			begin
				rdata_d = cfg_q;
			end
			`FSP_ADDR_PROT:
			begin
				rdata_d = prot_q;
			end
			`FSP_ADDR_STAT:
			begin
				rdata_d = {5'h00, key_sel, loaded_q, secure_o};
			end
			default:
			begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// read data stands for one cycle after the strobe only
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o <= 8'h00;
		end
		else if (reg_rd_i)
		begin
			reg_rdata_o <= rdata_d;
		end
		else
		begin
			reg_rdata_o <= 8'h00;
		end
	end

	// key window steering
	assign cmd_launch_o = flash_wr_i && !(in_key_win && key_sel);
	assign flash_read_invalid_o = key_sel;

	// security decode
	assign secure_o = !fsp_is_open(opt_q[1:0]);
	assign access_block_o = secure_o && access_unsecured_src_i;

	// program/erase protection against the shadowed block
	always @*
	begin
		size_code = prot_q[5:3];
		prot_base = fsp_prot_base(size_code);
		in_block = 1'b0;
		if (!prot_q[`FSP_PROT_OFF])
		begin
			in_block = (pe_addr_i >= prot_base);
		end
		pe_ok = 1'b0;
		if (loaded_q && prot_q[`FSP_PROT_OPEN])
		begin
			pe_ok = !in_block;
		end
	end
	assign pe_allowed_o = pe_ok;

	// redirection enable, big tables only on big memory variants
	always @*
	begin
		case (size_code)
			3'h6:
			begin
				variant_ok = (MEM_KB >= 60);
			end
			3'h5:
			begin
				variant_ok = (MEM_KB >= 32);
			end
			default:
			begin
				variant_ok = 1'b1;
			end
		endcase
		redirect_on = 1'b0;
		if (!opt_q[`FSP_OPT_NORED] && prot_q[`FSP_PROT_OPEN])
		begin
			redirect_on = !prot_q[`FSP_PROT_OFF] && (size_code != `FSP_SIZE_LAST)
				&& variant_ok;
		end
	end
	assign redirect_active_o = redirect_on;

	// vector fetch address, reset vector always passes through
	always @*
	begin
		is_vec = fsp_in_range(vec_addr_i, `FSP_VEC_BASE, `FSP_VEC_TOP)
			&& ((vec_addr_i | 16'h0001) != `FSP_VEC_TOP);
		redir_base = fsp_redir_base(size_code);
		redir = redir_base | {10'h000, vec_addr_i[5:0]};
		vec_out = vec_addr_i;
		if (redirect_on && is_vec)
		begin
			vec_out = redir;
		end
	end
	assign vec_addr_o = vec_out;
endmodule

// ### testbench/fsp_flash_protect_props.sv
`timescale 1ns/1ps
// watches register reads, key window steering, access blocking and vector fetch
module fsp_flash_protect_props (
	// clock, reset and register port
	input wire ref_clk_i, input wire rst_n_i, input wire reg_wr_i, input wire reg_rd_i,
	input wire [1:0] reg_addr_i, input wire [7:0] reg_wdata_i, input wire [7:0] reg_rdata_o,
	// key window and status
	input wire flash_wr_i, input wire [15:0] flash_waddr_i, input wire cmd_launch_o,
	input wire flash_read_invalid_o, input wire secure_o, input wire redirect_active_o,
	input wire access_unsecured_src_i, input wire access_block_o,
	// vector fetch
	input wire [15:0] vec_addr_i, input wire [15:0] vec_addr_o
);
	// write falls in the eight-byte key window
	wire in_win = flash_waddr_i[15:3] == 13'h1FF6;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_opt_zero_bits: assert property (reg_rd_i && reg_addr_i == 2'h0 |=>
		reg_rdata_o[5:2] == 4'h0) else $error("options unused bits not zero");
	a_cfg_zero_bits: assert property (reg_rd_i && reg_addr_i == 2'h1 |=>
		reg_rdata_o[4:0] == 5'h00) else $error("config low bits not zero");
	a_prot_zero_bits: assert property (reg_rd_i && reg_addr_i == 2'h2 |=>
		reg_rdata_o[2:0] == 3'h0) else $error("protection low bits not zero");
	a_keysel_set: assert property (reg_wr_i && reg_addr_i == 2'h1 && reg_wdata_i[5] |=>
		flash_read_invalid_o) else $error("reads not invalid after key select");
	a_key_no_launch: assert property (flash_wr_i && in_win && flash_read_invalid_o |->
		!cmd_launch_o) else $error("key byte launched a command");
	a_cmd_launch: assert property (flash_wr_i && in_win && !flash_read_invalid_o |->
		cmd_launch_o) else $error("window write did not launch");
	a_reset_vec_kept: assert property (vec_addr_i[15:1] == 15'h7FFF |->
		vec_addr_o == vec_addr_i) else $error("reset vector moved");
	a_no_redirect_pass: assert property (!redirect_active_o |->
		vec_addr_o == vec_addr_i) else $error("vector moved while redirect off");
	a_redirect_offset: assert property (redirect_active_o && vec_addr_i[15:6] == 10'h3FF |->
		vec_addr_o[5:0] == vec_addr_i[5:0]) else $error("vector offset lost");
	a_secure_blocks: assert property (secure_o && access_unsecured_src_i |->
		access_block_o) else $error("secure access not blocked");
	// main scenarios
	c_unlock: cover property ($fell(secure_o));
	c_redirect: cover property (redirect_active_o && vec_addr_o != vec_addr_i);
	c_launch: cover property (cmd_launch_o);
endmodule

// ### testbench/fsp_flash_protect_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("FAIL %0t %h %h", $time, a, b); end end
module fsp_flash_protect_tb;
	// stimulus and observed ports, named as the design's ports
	reg ref_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, background_debug_mode_i = 0;
	reg flash_wr_i = 0, flash_wr_debug_i = 0, blank_ok_i = 0, access_unsecured_src_i = 1;
	reg [1:0] reg_addr_i = 0;
	reg [7:0] reg_wdata_i = 0, flash_wdata_i = 0, options_nv_byte_i = 8'hBC;
	reg [7:0] protection_nv_byte_i = 8'hFF;
	reg [15:0] flash_waddr_i = 0, pe_addr_i = 16'hFE00, vec_addr_i = 16'hFFFE;
	reg [63:0] stored_backdoor_key_i = 64'h0123456789ABCDEF;
	wire [7:0] reg_rdata_o;
	wire [15:0] vec_addr_o;
	wire cmd_launch_o, pe_allowed_o, access_block_o, flash_read_invalid_o, secure_o;
	wire redirect_active_o;
	int bad_count = 0, n_checks = 0, i;
	fsp_flash_protect #(.MEM_KB(60)) i_dut (.*);
	always #2.5 ref_clk_i = ~ref_clk_i;
	// one-cycle register write
	task wr(input [1:0] a, input [7:0] d);
		begin
			@(posedge ref_clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
			@(posedge ref_clk_i) reg_wr_i <= 1'b0;
			#1;
		end
	endtask
	// read strobe, data checked in the following cycle only
	task rd(input [1:0] a, input [7:0] e);
		begin
			@(posedge ref_clk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
			@(posedge ref_clk_i) reg_rd_i <= 1'b0;
			#1 `CHK(reg_rdata_o, e)
		end
	endtask
	// eight key bytes into the window, byte n at offset n
	task key(input dbg);
		begin
			for (i = 0; i < 8; i++)
				@(posedge ref_clk_i) {flash_wr_i, flash_wr_debug_i, flash_waddr_i, flash_wdata_i}
					<= {2'b10 | dbg, 16'hFFB0 + i[15:0], stored_backdoor_key_i[63 - 8 * i -: 8]};
			@(posedge ref_clk_i) flash_wr_i <= 1'b0;
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", n_checks, bad_count);
			if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// tests: reset load, config and key unlock, protection and redirection
	initial begin
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rd(2'h0, 8'h80);
		rd(2'h2, 8'hF8);
		`CHK(secure_o, 1'b1)
		$display("test reset load done");
		wr(2'h1, 8'hFF);
		rd(2'h1, 8'hE0);
		`CHK(flash_read_invalid_o, 1'b1)
		key(1'b1);
		wr(2'h1, 8'h00);
		`CHK(secure_o, 1'b1)
		wr(2'h1, 8'h20);
		key(1'b0);
		wr(2'h0, 8'hFF);
		wr(2'h1, 8'h00);
		`CHK(secure_o, 1'b0)
		`CHK(access_block_o, 1'b0)
		rd(2'h0, 8'h82);
		$display("test key unlock done");
		wr(2'h2, 8'h00);
		rd(2'h2, 8'hF8);
		@(posedge ref_clk_i) background_debug_mode_i <= 1'b1;
		wr(2'h2, 8'h00);
		rd(2'h2, 8'h00);
		`CHK(pe_allowed_o, 1'b0)
		wr(2'h2, 8'h80);
		`CHK(pe_allowed_o, 1'b0)
		@(posedge ref_clk_i) {pe_addr_i, vec_addr_i} <= {16'hFDFF, 16'hFFC4};
		@(posedge ref_clk_i) {flash_wr_i, flash_waddr_i} <= {1'b1, 16'hFFB3};
		#1 `CHK(cmd_launch_o, 1'b1)
		`CHK(pe_allowed_o, 1'b1)
		`CHK(vec_addr_o, 16'hFDC4)
		@(posedge ref_clk_i) {flash_wr_i, vec_addr_i} <= {1'b0, 16'hFFFE};
		#1 `CHK(vec_addr_o, 16'hFFFE)
		$display("test protect done");
		// second reset reloads new option and protection bytes
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		options_nv_byte_i <= 8'h40;
		protection_nv_byte_i <= 8'h80;
		vec_addr_i <= 16'hFFC4;
		pe_addr_i <= 16'hFFFF;
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rd(2'h0, 8'h40);
		`CHK(redirect_active_o, 1'b0)
		`CHK(vec_addr_o, 16'hFFC4)
		`CHK(pe_allowed_o, 1'b0)
		wr(2'h1, 8'h20);
		key(1'b0);
		wr(2'h1, 8'h00);
		`CHK(secure_o, 1'b1)
		wr(2'h2, 8'hC0);
		`CHK(pe_allowed_o, 1'b1)
		@(posedge ref_clk_i) blank_ok_i <= 1'b1;
		@(posedge ref_clk_i) blank_ok_i <= 1'b0;
		#1 `CHK(secure_o, 1'b0)
		$display("test second reset done");
		wrap_up;
	end
	// hang guard, far beyond the roughly ninety cycles the tests need
	initial begin
		#20000 bad_count++;
		wrap_up;
	end
endmodule
bind fsp_flash_protect fsp_flash_protect_props i_props (.*);
